// ===== rsi_consts.svh
// constants of the reset state initialiser: offsets, reset values, timing
// Function
// RULE_01 - power-on clears timeout and power-down flags
// RULE_02 - low supply reset leaves both flags
// RULE_03 - running watchdog expiry sets timeout flag only
// RULE_04 - sleeping watchdog expiry sets both flags
// RULE_05 - power-on disables every interrupt source
// RULE_06 - power-on clears watchdog, time base; restarts
// RULE_07 - power-on switches the timer module off
// RULE_08 - power-on makes every port pin input
// RULE_09 - power-on gives analogue pins to converter
// RULE_10 - power-on points stack pointer at top
// RULE_11 - every reset clears program counter low byte
// RULE_12 - halt and watchdog clear steer the flags
// RULE_13 - power-on forces program counter to zero
// RULE_14 - sleeping watchdog expiry clears only counter, stack
// RULE_15 - power-on beats low supply beats watchdog
`ifndef RSI_CONSTS_SVH
`define RSI_CONSTS_SVH

// register offsets on the plain register port
`define RSI_OFF_STATUS     8'h00
`define RSI_OFF_CAUSE      8'h04
`define RSI_OFF_GPIO_DIR   8'h08
`define RSI_OFF_ANALOG_SEL 8'h0C
`define RSI_OFF_INT_EN     8'h10
`define RSI_OFF_TIMER_CTRL 8'h14

// field positions
`define RSI_BIT_TIMEOUT    0
`define RSI_BIT_POWER_DOWN 1
`define RSI_BIT_TIMER_ON   0

// initial values forced by a full reset
`define RSI_RST_INT_EN     8'h00
`define RSI_RST_TIMER_ON   1'b0

// length of the core hold window
`define RSI_HOLD_NS        20
`define RSI_CLK_PERIOD_PS  5000
`define RSI_HOLD_CYC       ((`RSI_HOLD_NS * 1000 + `RSI_CLK_PERIOD_PS - 1) / `RSI_CLK_PERIOD_PS)

`endif

// ===== rsi_pkg.sv
// types of the reset state initialiser
package rsi_pkg;

  // power mode reported by the core
  typedef enum logic [1:0] {
    RSI_MODE_FAST  = 2'h0,
    RSI_MODE_SLOW  = 2'h1,
    RSI_MODE_IDLE  = 2'h2,
    RSI_MODE_SLEEP = 2'h3
  } rsi_mode_e;

  // cause of the last reset, readable by software
  typedef enum logic [2:0] {
    RSI_CAUSE_NONE      = 3'h0,
    RSI_CAUSE_POR       = 3'h1,
    RSI_CAUSE_LVR       = 3'h2,
    RSI_CAUSE_WDT_RUN   = 3'h3,
    RSI_CAUSE_WDT_SLEEP = 3'h4
  } rsi_cause_e;

  // sequencer states
  typedef enum logic {
    RSI_ST_APPLY,
    RSI_ST_RUN
  } rsi_state_e;

endpackage : rsi_pkg

// ===== rsi_sync.sv
// two flip-flop synchroniser for detector levels
`timescale 1ns/100ps
module rsi_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // first stage, read only by the second stage
  logic [W-1:0] meta_r;

  // both stages clear under reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : rsi_sync

// ===== rsi_top.sv
// reset state initialiser: cause capture, flags, initial state distribution
`timescale 1ns/100ps
`include "rsi_consts.svh"
module rsi_top #(
  parameter int unsigned GPIO_W = 8,              // general purpose pins
  parameter int unsigned AN_W   = 8,              // analogue-capable pins
  parameter int unsigned HOLD   = `RSI_HOLD_CYC   // core hold window in cycles
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              low_supply_reset,
  input  wire logic              watchdog_expire,
  input  wire rsi_pkg::rsi_mode_e mode,
  input  wire logic              halt_entry,
  input  wire logic              watchdog_clear_insn,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata_r,
  output logic                   core_hold_r,
  output logic                   pc_clear_r,
  output logic                   sp_top_r,
  output logic                   periph_init_r,
  output logic                   wdt_clear_r,
  output logic                   tb_clear_r,
  output logic                   timeout_flag_r,
  output logic                   power_down_flag_r,
  output logic      [GPIO_W-1:0] gpio_dir_r,
  output logic      [AN_W-1:0]   analogue_input_pins_r,
  output logic      [7:0]        int_en_r,
  output logic                   timer_on_r
);

  localparam int unsigned CNT_W = $clog2(HOLD + 1);

  // refuse sizes the logic cannot serve
  generate
    if (GPIO_W < 1 || GPIO_W > 32 || AN_W < 1 || AN_W > 32 || HOLD < 1) begin : g_bad
      $error("rsi_top: unsupported parameter values");
    end
  endgenerate

  // address match, shared by write and read decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // synchronised detector levels and their previous values
  logic [1:0] det_s;
  logic       lvr_s;
  logic       wdt_s;
  logic       lvr_d_r;
  logic       wdt_d_r;

  // detectors run outside this clock
  rsi_sync #(
    .W (2)
  ) u_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in ({low_supply_reset, watchdog_expire}),
    .sync_out (det_s)
  );

  assign lvr_s = det_s[1];
  assign wdt_s = det_s[0];

  // sequencer state
  rsi_pkg::rsi_state_e state_r;
  rsi_pkg::rsi_state_e state_nxt;
  rsi_pkg::rsi_cause_e cause_r;
  rsi_pkg::rsi_cause_e cause_nxt;
  logic [CNT_W-1:0]    cnt_r;
  logic [CNT_W-1:0]    cnt_nxt;

  // event detection on the synchronised levels
  wire lvr_rise = lvr_s && !lvr_d_r;
  wire wdt_rise = wdt_s && !wdt_d_r;
  wire running  = (mode == rsi_pkg::RSI_MODE_FAST) || (mode == rsi_pkg::RSI_MODE_SLOW);
  // a power-on window is never downgraded by a lesser cause
  wire por_busy = (state_r == rsi_pkg::RSI_ST_APPLY) && (cause_r == rsi_pkg::RSI_CAUSE_POR);

  // low supply detection is off in idle and sleep; low supply beats watchdog
  wire take_lvr     = lvr_rise && running && !por_busy;               // RULE_15
  wire take_wdt_run = wdt_rise && running && !take_lvr && !por_busy;  // RULE_15
  wire take_wdt_slp = wdt_rise && !running && !por_busy;
  wire take_full    = take_lvr || take_wdt_run;
  wire take_any     = take_full || take_wdt_slp;
  wire cnt_done     = (cnt_r == '0);

  // next state of the sequencer
  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      rsi_pkg::RSI_ST_APPLY: begin
        if (cnt_done) begin
          state_nxt = rsi_pkg::RSI_ST_RUN;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      rsi_pkg::RSI_ST_RUN: begin
        cnt_nxt = cnt_r;
      end
    endcase
    // a new cause restarts the window from any state
    if (take_any) begin
      state_nxt = rsi_pkg::RSI_ST_APPLY;
      cnt_nxt   = CNT_W'(HOLD - 1);
      if (take_lvr) begin
        cause_nxt = rsi_pkg::RSI_CAUSE_LVR;
      end else if (take_wdt_run) begin
        cause_nxt = rsi_pkg::RSI_CAUSE_WDT_RUN;
      end else begin
        cause_nxt = rsi_pkg::RSI_CAUSE_WDT_SLEEP;
      end
    end
  end

  // window outputs: full resets touch peripherals, sleep expiry does not
  wire apply_nxt  = (state_nxt == rsi_pkg::RSI_ST_APPLY);
  wire full_nxt   = apply_nxt && (cause_nxt != rsi_pkg::RSI_CAUSE_WDT_SLEEP);  // RULE_14

  // sequencer registers; power-on starts in the window
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= rsi_pkg::RSI_ST_APPLY;
      cause_r <= rsi_pkg::RSI_CAUSE_POR;
      cnt_r   <= CNT_W'(HOLD - 1);
      lvr_d_r <= 1'b0;
      wdt_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
      cnt_r   <= cnt_nxt;
      lvr_d_r <= lvr_s;
      wdt_d_r <= wdt_s;
    end
  end

  // core and counter orders
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      core_hold_r   <= 1'b1;
      pc_clear_r    <= 1'b1;  // RULE_13
      sp_top_r      <= 1'b1;  // RULE_10
      periph_init_r <= 1'b1;
      wdt_clear_r   <= 1'b1;  // RULE_06
      tb_clear_r    <= 1'b1;  // RULE_06
    end else begin
      core_hold_r   <= apply_nxt;
      pc_clear_r    <= apply_nxt;  // RULE_11
      sp_top_r      <= apply_nxt;  // RULE_14
      periph_init_r <= full_nxt;
      // one cycle only, so the watchdog runs again at once
      wdt_clear_r   <= take_full;  // RULE_06
      tb_clear_r    <= take_full;  // RULE_06
    end
  end

  // flag updates; hardware sets win over instruction clears
  logic timeout_nxt;
  logic power_down_nxt;
  always_comb begin
    timeout_nxt    = timeout_flag_r;
    power_down_nxt = power_down_flag_r;
    // halt sets power-down and clears timeout; watchdog clear clears both
    if (halt_entry) begin
      timeout_nxt    = 1'b0;  // RULE_12
      power_down_nxt = 1'b1;  // RULE_12
    end else if (watchdog_clear_insn) begin
      timeout_nxt    = 1'b0;  // RULE_12
      power_down_nxt = 1'b0;  // RULE_12
    end
    if (take_lvr) begin
      timeout_nxt    = timeout_flag_r;     // RULE_02
      power_down_nxt = power_down_flag_r;  // RULE_02
    end else if (take_wdt_run) begin
      timeout_nxt = 1'b1;  // RULE_03
    end else if (take_wdt_slp) begin
      timeout_nxt    = 1'b1;  // RULE_04
      power_down_nxt = 1'b1;  // RULE_04
    end
  end

  // flag registers, cleared by power-on
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timeout_flag_r    <= 1'b0;  // RULE_01
      power_down_flag_r <= 1'b0;  // RULE_01
    end else begin
      timeout_flag_r    <= timeout_nxt;
      power_down_flag_r <= power_down_nxt;
    end
  end

  // software writes are refused while the core is held or a reset lands
  wire wr_ok       = wr && !core_hold_r && !take_any;
  wire wr_gpio     = wr_ok && hit(addr, `RSI_OFF_GPIO_DIR);
  wire wr_analog   = wr_ok && hit(addr, `RSI_OFF_ANALOG_SEL);
  wire wr_int      = wr_ok && hit(addr, `RSI_OFF_INT_EN);
  wire wr_timer    = wr_ok && hit(addr, `RSI_OFF_TIMER_CTRL);

  // peripheral state forced during a full reset window
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gpio_dir_r            <= '1;                 // RULE_08
      analogue_input_pins_r <= '1;                 // RULE_09
      int_en_r              <= `RSI_RST_INT_EN;    // RULE_05
      timer_on_r            <= `RSI_RST_TIMER_ON;  // RULE_07
    end else if (full_nxt) begin
      gpio_dir_r            <= '1;                 // RULE_08
      analogue_input_pins_r <= '1;                 // RULE_09
      int_en_r              <= `RSI_RST_INT_EN;    // RULE_05
      timer_on_r            <= `RSI_RST_TIMER_ON;  // RULE_07
    end else begin
      if (wr_gpio) begin
        gpio_dir_r <= wdata[GPIO_W-1:0];
      end
      if (wr_analog) begin
        analogue_input_pins_r <= wdata[AN_W-1:0];
      end
      if (wr_int) begin
        int_en_r <= wdata[7:0];
      end
      if (wr_timer) begin
        timer_on_r <= wdata[`RSI_BIT_TIMER_ON];
      end
    end
  end

  // read selection; unmapped addresses read zero
  wire [31:0] rd_status = {30'h0000_0000, power_down_flag_r, timeout_flag_r};
  wire [31:0] rd_mux =
    hit(addr, `RSI_OFF_STATUS)     ? rd_status :
    hit(addr, `RSI_OFF_CAUSE)      ? {29'h0000_0000, cause_r} :
    hit(addr, `RSI_OFF_GPIO_DIR)   ? 32'(gpio_dir_r) :
    hit(addr, `RSI_OFF_ANALOG_SEL) ? 32'(analogue_input_pins_r) :
    hit(addr, `RSI_OFF_INT_EN)     ? {24'h00_0000, int_en_r} :
    hit(addr, `RSI_OFF_TIMER_CTRL) ? {31'h0000_0000, timer_on_r} :
                                     32'h0000_0000;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  // checks on the sequencer and flags
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  property p_lvr_keeps;
    take_lvr && !halt_entry && !watchdog_clear_insn |=>
      $stable(timeout_flag_r) && $stable(power_down_flag_r);
  endproperty
  a_lvr_keeps: assert property (p_lvr_keeps) // RULE_02
    else $error("low supply reset changed a flag");

  property p_wdt_run;
    take_wdt_run && !halt_entry && !watchdog_clear_insn |=>
      timeout_flag_r && $stable(power_down_flag_r);
  endproperty
  a_wdt_run: assert property (p_wdt_run) // RULE_03
    else $error("running expiry flags wrong");

  property p_wdt_slp;
    take_wdt_slp |=> timeout_flag_r && power_down_flag_r && !periph_init_r;
  endproperty
  a_wdt_slp: assert property (p_wdt_slp) // RULE_04
    else $error("sleep expiry flags wrong");

  property p_int_off;
    take_full |=> (int_en_r == 8'h00) && !timer_on_r;
  endproperty
  a_int_off: assert property (p_int_off) // RULE_05
    else $error("interrupts or timer left on");

  property p_wdt_pulse;
    take_full |=> wdt_clear_r && tb_clear_r ##1 !wdt_clear_r || $past(take_full);
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) // RULE_06
    else $error("watchdog clear not a single pulse");

  property p_pins;
    take_full |=> (&gpio_dir_r) && (&analogue_input_pins_r);
  endproperty
  a_pins: assert property (p_pins) // RULE_08
    else $error("pins not returned to inputs");

  property p_pc_any;
    take_any |=> pc_clear_r && sp_top_r && core_hold_r;
  endproperty
  a_pc_any: assert property (p_pc_any) // RULE_11
    else $error("counter or stack not cleared");

  property p_slp_keep;
    take_wdt_slp |=> $stable(gpio_dir_r) && $stable(int_en_r) && $stable(timer_on_r);
  endproperty
  a_slp_keep: assert property (p_slp_keep) // RULE_14
    else $error("sleep expiry touched peripherals");

  property p_prio;
    lvr_rise && wdt_rise && running && !por_busy |=>
      cause_r == rsi_pkg::RSI_CAUSE_LVR;
  endproperty
  a_prio: assert property (p_prio) // RULE_15
    else $error("watchdog beat low supply");

  property p_flag_cause;
    $rose(timeout_flag_r) |-> $past(take_wdt_run || take_wdt_slp);
  endproperty
  a_flag_cause: assert property (p_flag_cause) // RULE_12
    else $error("timeout flag rose without expiry");

  // halt entry alone: power-down set, timeout cleared
  property p_halt;
    halt_entry && !take_any |=> power_down_flag_r && !timeout_flag_r;
  endproperty
  a_halt: assert property (p_halt) // RULE_12
    else $error("halt entry flags wrong");

  // watchdog clear instruction alone: both flags cleared
  property p_clr_insn;
    watchdog_clear_insn && !halt_entry && !take_any |=> !timeout_flag_r && !power_down_flag_r;
  endproperty
  a_clr_insn: assert property (p_clr_insn) // RULE_12
    else $error("watchdog clear left a flag set");

  // main scenarios
  c_lvr:  cover property (take_lvr ##1 core_hold_r);
  c_run:  cover property (take_wdt_run ##1 timeout_flag_r);
  c_slp:  cover property (take_wdt_slp ##1 power_down_flag_r);
  c_halt: cover property (halt_entry ##1 power_down_flag_r);
  c_por:  cover property ($fell(core_hold_r) && (cause_r == rsi_pkg::RSI_CAUSE_POR));

endmodule : rsi_top

// ===== rsi_src_model.sv
// behavioural model of the reset source detectors beside the initialiser
`timescale 1ns/100ps
module rsi_src_model (
  input  wire logic mclk,             // system clock
  input  wire logic nrst,             // power-on reset, clears both levels
  input  wire logic fire_lvr,         // bench asks for a low supply episode
  input  wire logic fire_wdt,         // bench asks for a watchdog overflow
  output logic      low_supply_reset, // detector level, held a few cycles
  output logic      watchdog_expire   // overflow level, held a few cycles
);
  logic [2:0] lvr_cnt_r; // remaining cycles of the low supply level
  logic [2:0] wdt_cnt_r; // remaining cycles of the overflow level

  // a level held four cycles so the two-flop synchroniser surely sees it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lvr_cnt_r <= 3'h0;
      wdt_cnt_r <= 3'h0;
    end else begin
      lvr_cnt_r <= fire_lvr ? 3'h4 : lvr_cnt_r - {2'h0, lvr_cnt_r != 3'h0};
      wdt_cnt_r <= fire_wdt ? 3'h4 : wdt_cnt_r - {2'h0, wdt_cnt_r != 3'h0};
    end
  end

  assign low_supply_reset = (lvr_cnt_r != 3'h0);
  assign watchdog_expire  = (wdt_cnt_r != 3'h0);
endmodule : rsi_src_model

// ===== reset_state_initialiser_tb_top.sv
// testbench of the reset state initialiser: scenarios and verdict
`timescale 1ns/100ps
module reset_state_initialiser_tb_top;
  logic               mclk, nrst, fire_lvr, fire_wdt, low_supply_reset, watchdog_expire;
  logic               halt_entry, watchdog_clear_insn, wr, rd;
  rsi_pkg::rsi_mode_e mode;
  logic [7:0]         addr, int_en_r, gpio_dir_r, analogue_input_pins_r;
  logic [31:0]        wdata, rdata_r, snap;
  logic               core_hold_r, pc_clear_r, sp_top_r, periph_init_r, wdt_clear_r;
  logic               tb_clear_r, timeout_flag_r, power_down_flag_r, timer_on_r;
  logic [3:0]         seen;       // window outputs seen during one reset window
  int                 err_total;  // mismatches
  int                 num_checks; // comparisons

  // visible state in one word: port state, flags, window outputs
  assign snap = {gpio_dir_r, analogue_input_pins_r, int_en_r, timer_on_r, timeout_flag_r,
                 power_down_flag_r, core_hold_r, pc_clear_r, sp_top_r, wdt_clear_r, tb_clear_r};

  rsi_top #(.HOLD(2)) u_dut (
    .mclk, .nrst, .low_supply_reset, .watchdog_expire, .mode, .halt_entry,
    .watchdog_clear_insn, .addr, .wdata, .wr, .rd, .rdata_r, .core_hold_r, .pc_clear_r,
    .sp_top_r, .periph_init_r, .wdt_clear_r, .tb_clear_r, .timeout_flag_r,
    .power_down_flag_r, .gpio_dir_r, .analogue_input_pins_r, .int_en_r, .timer_on_r
  );

  rsi_src_model u_src (.mclk, .nrst, .fire_lvr, .fire_wdt, .low_supply_reset, .watchdog_expire);

  // 200 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // compare one value and count it
  task automatic chk(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
    num_checks++;
    if (seen_v !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen_v);
    end
  endtask : chk

  // counts, verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // one-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : wr_reg

  // one-cycle register read, data judged in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    chk("rdata", rdata_r, exp);
  endtask : rd_chk

  // one-cycle core pulse: halt entry or watchdog clear instruction
  task automatic core_pulse(input logic h, input logic c);
    @(posedge mclk);
    halt_entry          <= h;
    watchdog_clear_insn <= c;
    @(posedge mclk);
    halt_entry          <= 1'b0;
    watchdog_clear_insn <= 1'b0;
  endtask : core_pulse

  // raise detector levels, then follow the window to its end under a bound
  task automatic fire(input logic l, input logic w);
    int n;
    n    = 0;
    seen = 4'h0;
    @(posedge mclk);
    fire_lvr <= l;
    fire_wdt <= w;
    @(posedge mclk);
    fire_lvr <= 1'b0;
    fire_wdt <= 1'b0;
    while (core_hold_r !== 1'b1 && n < 12) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (core_hold_r !== 1'b1) begin
      err_total++;
      $display("wrong value window start: expected high seen low");
      print_verdict();
    end
    while (core_hold_r === 1'b1 && n < 30) begin
      seen = seen | {pc_clear_r, sp_top_r, periph_init_r, wdt_clear_r};
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 30) begin
      err_total++;
      $display("wrong value window end: expected low seen high");
      print_verdict();
    end
  endtask : fire

  // power-on state during reset and after release
  task automatic s_por;
    int n;
    n = 0;
    chk("por state", snap, 32'hFFFF_001F);
    @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("watchdog clear", {31'h0, wdt_clear_r}, 32'h0000_0000);
    while (core_hold_r === 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (core_hold_r === 1'b1) begin
      err_total++;
      $display("wrong value power-on hold end: expected low seen high");
      print_verdict();
    end
    rd_chk(8'h00, 32'h0000_0000);
    rd_chk(8'h04, 32'h0000_0001);
    $display("test por done");
  endtask : s_por

  // software writes, refused status write, unmapped read
  task automatic s_regs;
    wr_reg(8'h08, 32'h0000_0000);
    wr_reg(8'h0C, 32'h0000_000F);
    wr_reg(8'h10, 32'h0000_005A);
    wr_reg(8'h14, 32'h0000_0001);
    wr_reg(8'h00, 32'h0000_0003);
    rd_chk(8'h00, 32'h0000_0000);
    rd_chk(8'h20, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_005A);
    chk("written state", snap, 32'h000F_5A80);
    $display("test regs done");
  endtask : s_regs

  // watchdog expiry asleep: both flags, only counter and stack touched
  task automatic s_sleep;
    mode <= rsi_pkg::RSI_MODE_IDLE;
    fire(1'b0, 1'b1);
    chk("idle window", {28'h0, seen}, 32'h0000_000C);
    mode <= rsi_pkg::RSI_MODE_SLEEP;
    fire(1'b0, 1'b1);
    mode <= rsi_pkg::RSI_MODE_FAST;
    chk("sleep window", {28'h0, seen}, 32'h0000_000C);
    chk("sleep state", snap, 32'h000F_5AE0);
    rd_chk(8'h04, 32'h0000_0004);
    $display("test sleep done");
  endtask : s_sleep

  // halt sets power-down, low supply reset leaves flags, full init
  task automatic s_lvr;
    core_pulse(1'b1, 1'b0);
    rd_chk(8'h00, 32'h0000_0002);
    fire(1'b1, 1'b0);
    chk("lvr window", {28'h0, seen}, 32'h0000_000F);
    chk("lvr state", snap, 32'hFFFF_0020);
    rd_chk(8'h04, 32'h0000_0002);
    $display("test lvr done");
  endtask : s_lvr

  // clear instruction, running watchdog expiry, then both causes at once
  task automatic s_run;
    core_pulse(1'b0, 1'b1);
    rd_chk(8'h00, 32'h0000_0000);
    mode <= rsi_pkg::RSI_MODE_SLOW;
    fire(1'b0, 1'b1);
    chk("run window", {28'h0, seen}, 32'h0000_000F);
    chk("run state", snap, 32'hFFFF_0040);
    rd_chk(8'h04, 32'h0000_0003);
    mode <= rsi_pkg::RSI_MODE_FAST;
    fire(1'b1, 1'b1);
    rd_chk(8'h04, 32'h0000_0002);
    rd_chk(8'h00, 32'h0000_0001);
    $display("test run done");
  endtask : s_run

  // power-on in mid-run: flags and forced state return to their initial values
  task automatic s_repor;
    int n;
    n = 0;
    wr_reg(8'h08, 32'h0000_0000);
    wr_reg(8'h10, 32'h0000_00A5);
    @(posedge mclk);
    nrst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("repor state", snap, 32'hFFFF_001F);
    @(posedge mclk);
    nrst <= 1'b1;
    while (core_hold_r === 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (core_hold_r === 1'b1) begin
      err_total++;
      $display("wrong value repeat hold end: expected low seen high");
      print_verdict();
    end
    rd_chk(8'h00, 32'h0000_0000);
    rd_chk(8'h04, 32'h0000_0001);
    $display("test repor done");
  endtask : s_repor

  // main sequence
  initial begin
    err_total           = 0;
    num_checks          = 0;
    nrst                = 1'b0;
    fire_lvr            = 1'b0;
    fire_wdt            = 1'b0;
    mode                = rsi_pkg::RSI_MODE_FAST;
    halt_entry          = 1'b0;
    watchdog_clear_insn = 1'b0;
    addr                = 8'h00;
    wdata               = 32'h0000_0000;
    wr                  = 1'b0;
    rd                  = 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    s_por();
    s_regs();
    s_sleep();
    s_lvr();
    s_run();
    s_repor();
    print_verdict();
  end
endmodule : reset_state_initialiser_tb_top
